// ---- rtl/amd_decoder.sv ----
// Prebyte and addressing mode decoder with its own byte fetch sequencer.
// Assumes the memory answers a held request with mem_ready and valid mem_rdata in that cycle.
`timescale 1ns/1ps

module amd_decoder (
  input wire logic clock,
  input wire logic reset,
  input wire logic start,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] index_x,
  input wire logic [7:0] index_y,
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_ready,
  input wire logic [7:0] mem_rdata,
  output logic busy,
  output logic done,
  output logic illegal_reset,
  output logic [7:0] opcode,
  output logic [7:0] prebyte,
  output logic has_prebyte,
  output amd_pkg::amd_mode_t addr_mode,
  output amd_pkg::amd_group_t op_group,
  output logic use_second_index,
  output logic [2:0] instr_len,
  output logic [15:0] operand,
  output logic [15:0] pointer,
  output logic [15:0] next_pc,
  output logic [15:0] eff_addr,
  output logic [15:0] branch_target
);
  import amd_pkg::*;

  amd_state_t state, next_state;
  logic [15:0] next_mem_addr, next_next_pc;
  logic [7:0] next_opcode, next_prebyte, ptr_base, next_ptr_base;
  logic next_has_prebyte, next_use_second_index, next_illegal_reset;
  amd_mode_t next_addr_mode;
  amd_group_t next_op_group;
  logic [2:0] next_instr_len;
  logic [1:0] ext_left, next_ext_left, ptr_left, next_ptr_left;
  logic [15:0] next_operand, next_pointer;
  logic ea_load, take;

  // Decode of the byte on the fetch path
  amd_mode_t d_mode;
  logic [1:0] d_ext, d_ptr;
  logic d_legal, d_is_prefix, d_second;
  logic [3:0] col, low;

  // ----------------------------------------
  // Functional group of an opcode
  // ----------------------------------------
  function automatic amd_group_t group_of(input logic [7:0] opc);
    amd_group_t g;
    g = AMD_G_LOAD;
    case (opc[7:4])
      4'h0: g = AMD_G_BIT_BRANCH;
      4'h1: g = AMD_G_BIT;
      4'h2: g = (opc[3:1] == 3'h0) ? AMD_G_JUMP : AMD_G_COND_BRANCH;
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
        case (opc[3:0])
          4'h0, 4'h3: g = AMD_G_LOGIC;
          4'h2: g = AMD_G_ARITH;
          4'ha, 4'hc: g = AMD_G_INCDEC;
          4'hd: g = AMD_G_COMPARE;
          4'hf: g = AMD_G_LOAD;
          default: g = AMD_G_SHIFT;
        endcase
      end
      4'h8: begin
        case (opc[3:0])
          4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha: g = AMD_G_STACK;
          4'h1: g = AMD_G_JUMP;
          default: g = AMD_G_INTERRUPT;
        endcase
      end
      4'h9: begin
        case (opc[3:0])
          4'h8, 4'h9, 4'ha, 4'hb: g = AMD_G_FLAGS;
          4'hc: g = AMD_G_STACK;
          4'hd: g = AMD_G_JUMP;
          default: g = AMD_G_LOAD;
        endcase
      end
      default: begin
        case (opc[3:0])
          4'h0, 4'h2, 4'h9, 4'hb: g = AMD_G_ARITH;
          4'h1, 4'h3, 4'h5: g = AMD_G_COMPARE;
          4'h4, 4'h8, 4'ha: g = AMD_G_LOGIC;
          4'hc, 4'hd: g = AMD_G_JUMP;
          default: g = AMD_G_LOAD;
        endcase
      end
    endcase
    return g;
  endfunction

  // ----------------------------------------
  // Opcode and prebyte decode
  // ----------------------------------------
  always_comb begin
    col = mem_rdata[7:4];
    low = mem_rdata[3:0];
    d_mode = AMD_INHERENT;
    d_ext = 2'h0;
    d_ptr = 2'h0;
    d_legal = 1'b1;
    d_second = 1'b0;
    d_is_prefix = (mem_rdata == AMD_SECOND_INDEX_PREFIX) ||
                  (mem_rdata == AMD_SECOND_INDEX_INDIRECT_PREFIX) ||
                  (mem_rdata == AMD_INDIRECT_PREFIX);
    case (col)
      4'h0: begin
        d_mode = AMD_BIT_DIR_REL;
        d_ext = 2'h2;
      end
      4'h1: begin
        d_mode = AMD_BIT_DIR;
        d_ext = 2'h1;
      end
      4'h2: begin
        d_mode = AMD_REL_DIR;
        d_ext = 2'h1;
      end
      // Read-modify-write forms exist in short shapes only
      4'h3, 4'h6: begin
        d_mode = (col == 4'h3) ? AMD_SHORT_DIR : AMD_IDX_SHORT;
        d_ext = 2'h1;
        d_legal = !(low == 4'h1 || low == 4'h2 || low == 4'h5 || low == 4'hb);
      end
      4'h7: begin
        d_mode = AMD_IDX_NONE;
        d_legal = !(low == 4'h1 || low == 4'h2 || low == 4'h5 || low == 4'hb);
      end
      4'h4, 4'h5: begin
        d_legal = !(low == 4'h1 || (low == 4'h2 && col == 4'h5) || low == 4'h5 || low == 4'hb);
      end
      4'h8: begin
        d_legal = !(low == 4'h2 || low == 4'h7 || low == 4'hb || low == 4'hc || low == 4'hd);
      end
      4'h9: begin
        // A prebyte seen where an opcode is due matches no opcode
        d_legal = !d_is_prefix || !has_prebyte;
      end
      4'ha: begin
        d_mode = (low == 4'hd) ? AMD_REL_DIR : AMD_IMM;
        d_ext = 2'h1;
        d_legal = !(low == 4'h7 || low == 4'hc || low == 4'hf);
      end
      4'hb: begin
        d_mode = AMD_SHORT_DIR;
        d_ext = 2'h1;
      end
      4'hc: begin
        d_mode = AMD_LONG_DIR;
        d_ext = 2'h2;
      end
      4'hd: begin
        d_mode = AMD_IDX_LONG;
        d_ext = 2'h2;
      end
      4'he: begin
        d_mode = AMD_IDX_SHORT;
        d_ext = 2'h1;
      end
      default: d_mode = AMD_IDX_NONE;
    endcase
    // Unauthorised pairs fall back to the plain decode, never to a reset
    if (has_prebyte && prebyte == AMD_SECOND_INDEX_PREFIX) begin
      d_second = 1'b1;
    end else if (has_prebyte && prebyte == AMD_SECOND_INDEX_INDIRECT_PREFIX) begin
      if (d_mode == AMD_IDX_SHORT) begin
        d_mode = AMD_INDIDX_SHORT;
        d_ptr = 2'h1;
        d_second = 1'b1;
      end else if (d_mode == AMD_IDX_LONG) begin
        d_mode = AMD_INDIDX_LONG;
        d_ext = 2'h1;
        d_ptr = 2'h2;
        d_second = 1'b1;
      end
    end else if (has_prebyte && prebyte == AMD_INDIRECT_PREFIX) begin
      case (d_mode)
        AMD_SHORT_DIR: begin
          d_mode = AMD_IND_SHORT;
          d_ptr = 2'h1;
        end
        AMD_LONG_DIR: begin
          d_mode = AMD_IND_LONG;
          d_ext = 2'h1;
          d_ptr = 2'h2;
        end
        AMD_IDX_SHORT: begin
          d_mode = AMD_INDIDX_SHORT;
          d_ptr = 2'h1;
        end
        AMD_IDX_LONG: begin
          d_mode = AMD_INDIDX_LONG;
          d_ext = 2'h1;
          d_ptr = 2'h2;
        end
        AMD_REL_DIR: begin
          d_mode = AMD_REL_IND;
          d_ptr = 2'h1;
        end
        AMD_BIT_DIR: begin
          d_mode = AMD_BIT_IND;
          d_ptr = 2'h1;
        end
        AMD_BIT_DIR_REL: begin
          d_mode = AMD_BIT_IND_REL;
          d_ptr = 2'h1;
        end
        default: d_ptr = 2'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Fetch sequencer
  // ----------------------------------------
  assign take = mem_req && mem_ready;

  always_comb begin
    next_state = state;
    next_mem_addr = mem_addr;
    next_next_pc = next_pc;
    next_opcode = opcode;
    next_prebyte = prebyte;
    next_has_prebyte = has_prebyte;
    next_use_second_index = use_second_index;
    next_addr_mode = addr_mode;
    next_op_group = op_group;
    next_instr_len = instr_len;
    next_ext_left = ext_left;
    next_ptr_left = ptr_left;
    next_operand = operand;
    next_pointer = pointer;
    next_ptr_base = ptr_base;
    next_illegal_reset = 1'b0;
    ea_load = 1'b0;
    case (state)
      AMD_S_IDLE, AMD_S_DONE: begin
        if (start) begin
          next_state = AMD_S_OPC;
          next_mem_addr = pc_in;
          next_next_pc = pc_in;
          next_has_prebyte = 1'b0;
          next_prebyte = AMD_RESET_BYTE;
          next_operand = AMD_RESET_WORD;
          next_pointer = AMD_RESET_WORD;
        end
      end
      AMD_S_OPC: begin
        if (take) begin
          next_next_pc = 16'(next_pc + AMD_ONE);
          next_mem_addr = 16'(next_pc + AMD_ONE);
          if (d_is_prefix && !has_prebyte) begin
            next_prebyte = mem_rdata;
            next_has_prebyte = 1'b1;
          end else if (!d_legal) begin
            next_illegal_reset = 1'b1;
            next_state = AMD_S_IDLE;
          end else begin
            next_opcode = mem_rdata;
            next_addr_mode = d_mode;
            next_op_group = group_of(mem_rdata);
            next_use_second_index = d_second;
            next_ext_left = d_ext;
            next_ptr_left = d_ptr;
            next_instr_len = 3'({2'h0, has_prebyte} + 3'h1 + {1'b0, d_ext});
            next_state = (d_ext != 2'h0) ? AMD_S_EXT : AMD_S_CALC;
          end
        end
      end
      AMD_S_EXT: begin
        if (take) begin
          next_operand = {operand[7:0], mem_rdata};
          next_next_pc = 16'(next_pc + AMD_ONE);
          next_mem_addr = 16'(next_pc + AMD_ONE);
          next_ext_left = 2'(ext_left - 2'h1);
          if (ext_left == 2'h1) begin
            // Bit-relative forms put the offset last, after the direct or pointer address
            next_ptr_base = (addr_mode == AMD_BIT_IND_REL) ? operand[7:0] : mem_rdata;
            if (ptr_left != 2'h0) begin
              next_state = AMD_S_PTR;
              next_mem_addr = {AMD_PAGE_ZERO, next_ptr_base};
            end else begin
              next_state = AMD_S_CALC;
            end
          end
        end
      end
      AMD_S_PTR: begin
        if (take) begin
          next_pointer = {pointer[7:0], mem_rdata};
          next_ptr_left = 2'(ptr_left - 2'h1);
          // Second pointer byte stays in page zero
          next_ptr_base = 8'(ptr_base + 8'h01);
          next_mem_addr = {AMD_PAGE_ZERO, next_ptr_base};
          if (ptr_left == 2'h1) begin
            next_state = AMD_S_CALC;
          end
        end
      end
      AMD_S_CALC: begin
        ea_load = 1'b1;
        next_state = AMD_S_DONE;
      end
      default: next_state = AMD_S_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= AMD_S_IDLE;
      mem_addr <= AMD_RESET_WORD;
      next_pc <= AMD_RESET_WORD;
      opcode <= AMD_RESET_BYTE;
      prebyte <= AMD_RESET_BYTE;
      has_prebyte <= 1'b0;
      use_second_index <= 1'b0;
      addr_mode <= AMD_INHERENT;
      op_group <= AMD_G_LOAD;
      instr_len <= 3'h0;
      ext_left <= 2'h0;
      ptr_left <= 2'h0;
      operand <= AMD_RESET_WORD;
      pointer <= AMD_RESET_WORD;
      ptr_base <= AMD_RESET_BYTE;
      illegal_reset <= 1'b0;
    end else begin
      state <= next_state;
      mem_addr <= next_mem_addr;
      next_pc <= next_next_pc;
      opcode <= next_opcode;
      prebyte <= next_prebyte;
      has_prebyte <= next_has_prebyte;
      use_second_index <= next_use_second_index;
      addr_mode <= next_addr_mode;
      op_group <= next_op_group;
      instr_len <= next_instr_len;
      ext_left <= next_ext_left;
      ptr_left <= next_ptr_left;
      operand <= next_operand;
      pointer <= next_pointer;
      ptr_base <= next_ptr_base;
      illegal_reset <= next_illegal_reset;
    end
  end

  assign mem_req = (state == AMD_S_OPC) || (state == AMD_S_EXT) || (state == AMD_S_PTR);
  assign done = (state == AMD_S_DONE);
  assign busy = !((state == AMD_S_IDLE) || (state == AMD_S_DONE));

  // ----------------------------------------
  // Address former
  // ----------------------------------------
  amd_ea_unit u_ea (
    .clock(clock),
    .reset(reset),
    .load(ea_load),
    .mode(addr_mode),
    .operand(operand),
    .pointer(pointer),
    .index(use_second_index ? index_y : index_x),
    .next_pc(next_pc),
    .eff_addr(eff_addr),
    .branch_target(branch_target)
  );

endmodule

// ---- rtl/amd_ea_unit.sv ----
// Effective address and branch target former, registered on a load strobe.
// Assumes operand and pointer words are already assembled high byte first.
`timescale 1ns/1ps

module amd_ea_unit (
  input wire logic clock,
  input wire logic reset,
  input wire logic load,
  input wire amd_pkg::amd_mode_t mode,
  input wire logic [15:0] operand,
  input wire logic [15:0] pointer,
  input wire logic [7:0] index,
  input wire logic [15:0] next_pc,
  output logic [15:0] eff_addr,
  output logic [15:0] branch_target
);
  import amd_pkg::*;

  logic [15:0] next_eff_addr;
  logic [15:0] next_branch_target;
  logic [15:0] idx16;
  logic [15:0] rel_off;

  // ----------------------------------------
  // Address arithmetic
  // ----------------------------------------
  always_comb begin
    idx16 = {AMD_PAGE_ZERO, index};
    rel_off = AMD_RESET_WORD;
    next_eff_addr = eff_addr;
    next_branch_target = branch_target;
    if (load) begin
      next_eff_addr = AMD_RESET_WORD;
      next_branch_target = next_pc;
      case (mode)
        AMD_IMM: next_eff_addr = 16'(next_pc - AMD_ONE);
        AMD_SHORT_DIR, AMD_BIT_DIR: next_eff_addr = {AMD_PAGE_ZERO, operand[7:0]};
        AMD_LONG_DIR: next_eff_addr = operand;
        AMD_IDX_NONE: next_eff_addr = idx16;
        // Sum of two bytes reaches 1FE at most, so no page wrap
        AMD_IDX_SHORT: next_eff_addr = 16'({AMD_PAGE_ZERO, operand[7:0]} + idx16);
        AMD_IDX_LONG: next_eff_addr = 16'(operand + idx16);
        AMD_IND_SHORT, AMD_BIT_IND: next_eff_addr = {AMD_PAGE_ZERO, pointer[7:0]};
        AMD_IND_LONG: next_eff_addr = pointer;
        AMD_INDIDX_SHORT: next_eff_addr = 16'({AMD_PAGE_ZERO, pointer[7:0]} + idx16);
        AMD_INDIDX_LONG: next_eff_addr = 16'(pointer + idx16);
        AMD_REL_DIR: begin
          rel_off = {{8{operand[7]}}, operand[7:0]};
          next_branch_target = 16'(next_pc + rel_off);
        end
        AMD_REL_IND: begin
          rel_off = {{8{pointer[7]}}, pointer[7:0]};
          next_branch_target = 16'(next_pc + rel_off);
        end
        AMD_BIT_DIR_REL: begin
          next_eff_addr = {AMD_PAGE_ZERO, operand[15:8]};
          rel_off = {{8{operand[7]}}, operand[7:0]};
          next_branch_target = 16'(next_pc + rel_off);
        end
        AMD_BIT_IND_REL: begin
          next_eff_addr = {AMD_PAGE_ZERO, pointer[7:0]};
          rel_off = {{8{operand[7]}}, operand[7:0]};
          next_branch_target = 16'(next_pc + rel_off);
        end
        default: next_eff_addr = AMD_RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      eff_addr <= AMD_RESET_WORD;
      branch_target <= AMD_RESET_WORD;
    end else begin
      eff_addr <= next_eff_addr;
      branch_target <= next_branch_target;
    end
  end

endmodule

// ---- rtl/amd_pkg.sv ----
// Constants, encodings and types shared by the addressing mode decoder.
// Assumes one core clock and a byte-wide memory fetch path shared by program and data.
//
// Behaviour
// - Immediate: opcode plus one value byte, limited ops
// - Short direct: one address byte, page zero
// - Long direct: two address bytes, full space
// - Indexed address is index plus offset, unsigned
// - No-offset indexed: no extra byte, index alone
// - Short indexed: one offset byte, up to 1FE
// - Long indexed: two offset bytes, full space
// - Short indirect: byte pointer read from page zero
// - Long indirect forms: word pointer from page zero
// - Indirect indexed: fetched pointer plus index register
// - Short indirect indexed: byte pointer, up to 1FE
// - Relative: PC plus sign-extended 8-bit offset
// - Offset follows opcode, or its address does
// - Only listed ops have long forms
// - Instruction set of 63 instructions, 13 groups
// - Instructions are one to four bytes long
// - Prebyte, opcode, then zero to two bytes
// - Three prebytes modify the following opcode
// - Prebyte 90 selects the second index register
// - Prebyte 92 turns direct/indexed into indirect
// - Prebyte 91 selects second index when indirect
// - Byte matching no opcode or prebyte resets
// - Unauthorised prebyte/opcode pairs cause no reset
// - Offset added to PC of next instruction

package amd_pkg;

  // ----------------------------------------
  // Instruction set figures
  // ----------------------------------------
  localparam int AMD_INSTR_COUNT = 63;
  localparam int AMD_GROUP_COUNT = 13;
  localparam int AMD_OPCODE_SPACE = 256;
  localparam logic [2:0] AMD_MAX_LEN = 3'h4;

  // ----------------------------------------
  // Prebyte values
  // ----------------------------------------
  localparam logic [7:0] AMD_SECOND_INDEX_PREFIX = 8'h90;
  localparam logic [7:0] AMD_SECOND_INDEX_INDIRECT_PREFIX = 8'h91;
  localparam logic [7:0] AMD_INDIRECT_PREFIX = 8'h92;

  // ----------------------------------------
  // Reset values and fixed constants
  // ----------------------------------------
  localparam logic [15:0] AMD_RESET_WORD = 16'h0000;
  localparam logic [7:0] AMD_RESET_BYTE = 8'h00;
  localparam logic [7:0] AMD_PAGE_ZERO = 8'h00;
  localparam logic [15:0] AMD_ONE = 16'h0001;

  // ----------------------------------------
  // Fetch sequencer states
  // ----------------------------------------
  typedef enum logic [5:0] {
    AMD_S_IDLE = 6'b00_0001,
    AMD_S_OPC = 6'b00_0010,
    AMD_S_EXT = 6'b00_0100,
    AMD_S_PTR = 6'b00_1000,
    AMD_S_CALC = 6'b01_0000,
    AMD_S_DONE = 6'b10_0000
  } amd_state_t;

  // ----------------------------------------
  // Addressing modes
  // ----------------------------------------
  typedef enum logic [4:0] {
    AMD_INHERENT = 5'h00,
    AMD_IMM = 5'h01,
    AMD_SHORT_DIR = 5'h02,
    AMD_LONG_DIR = 5'h03,
    AMD_IDX_NONE = 5'h04,
    AMD_IDX_SHORT = 5'h05,
    AMD_IDX_LONG = 5'h06,
    AMD_IND_SHORT = 5'h07,
    AMD_IND_LONG = 5'h08,
    AMD_INDIDX_SHORT = 5'h09,
    AMD_INDIDX_LONG = 5'h0a,
    AMD_REL_DIR = 5'h0b,
    AMD_REL_IND = 5'h0c,
    AMD_BIT_DIR = 5'h0d,
    AMD_BIT_IND = 5'h0e,
    AMD_BIT_DIR_REL = 5'h0f,
    AMD_BIT_IND_REL = 5'h10
  } amd_mode_t;

  // ----------------------------------------
  // Functional groups
  // ----------------------------------------
  typedef enum logic [3:0] {
    AMD_G_LOAD = 4'h0,
    AMD_G_STACK = 4'h1,
    AMD_G_INCDEC = 4'h2,
    AMD_G_COMPARE = 4'h3,
    AMD_G_LOGIC = 4'h4,
    AMD_G_BIT = 4'h5,
    AMD_G_BIT_BRANCH = 4'h6,
    AMD_G_ARITH = 4'h7,
    AMD_G_SHIFT = 4'h8,
    AMD_G_JUMP = 4'h9,
    AMD_G_COND_BRANCH = 4'ha,
    AMD_G_INTERRUPT = 4'hb,
    AMD_G_FLAGS = 4'hc
  } amd_group_t;

endpackage

// ---- verification/amd_decoder_assertions.sv ----
// Concurrent checks on the ports of the addressing mode decoder.
// Assumes one clock domain and the synchronous reset of the design.
`timescale 1ns/1ps

module amd_decoder_checker (
  input wire logic clock,
  input wire logic reset,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ready,
  input wire logic busy,
  input wire logic done,
  input wire logic illegal_reset,
  input wire logic has_prebyte,
  input wire amd_pkg::amd_mode_t addr_mode,
  input wire logic use_second_index,
  input wire logic [2:0] instr_len,
  input wire logic [7:0] index_x,
  input wire logic [7:0] index_y,
  input wire logic [15:0] operand,
  input wire logic [15:0] next_pc,
  input wire logic [15:0] eff_addr,
  input wire logic [15:0] branch_target
);
  import amd_pkg::*;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  logic [7:0] idx;
  assign idx = use_second_index ? index_y : index_x;

  // --------------------------------
  // Properties
  // --------------------------------
  chk_req_hold: assert property (mem_req && !mem_ready |=> mem_req && $stable(mem_addr))
    else $error("fetch request changed before it was answered");
  chk_len_range: assert property (done |-> instr_len >= 3'h1 && instr_len <= 3'h4)
    else $error("instruction length out of range");
  chk_imm_len: assert property (done && addr_mode == AMD_IMM && !has_prebyte |-> instr_len == 3'h2)
    else $error("immediate instruction not two bytes");
  chk_short_direct: assert property (done && addr_mode == AMD_SHORT_DIR |-> eff_addr == {8'h00, operand[7:0]})
    else $error("short direct address outside page zero");
  chk_long_direct: assert property (done && addr_mode == AMD_LONG_DIR |-> eff_addr == operand)
    else $error("long direct address wrong");
  // Index may change once done stands, so only the rising edge is judged
  chk_idx_short: assert property ($rose(done) && addr_mode == AMD_IDX_SHORT |->
    eff_addr == {8'h00, operand[7:0]} + {8'h00, idx}) else $error("short indexed sum wrong");
  chk_idx_none: assert property ($rose(done) && addr_mode == AMD_IDX_NONE |-> eff_addr == {8'h00, idx})
    else $error("no-offset indexed address wrong");
  chk_rel_target: assert property (done && addr_mode == AMD_REL_DIR |->
    branch_target == next_pc + {{8{operand[7]}}, operand[7:0]}) else $error("relative target wrong");
  chk_illegal_pulse: assert property (illegal_reset |-> !busy && !done ##1 !illegal_reset)
    else $error("illegal byte reset pulse malformed");

  cover property ($rose(done) && addr_mode == AMD_INDIDX_LONG);
  cover property (illegal_reset);
  cover property (mem_req && !mem_ready ##1 mem_ready);
endmodule

bind amd_decoder amd_decoder_checker chk_u (.clock(clock), .reset(reset), .mem_req(mem_req),
  .mem_addr(mem_addr), .mem_ready(mem_ready), .busy(busy), .done(done), .illegal_reset(illegal_reset),
  .has_prebyte(has_prebyte), .addr_mode(addr_mode), .use_second_index(use_second_index),
  .instr_len(instr_len), .index_x(index_x), .index_y(index_y), .operand(operand), .next_pc(next_pc),
  .eff_addr(eff_addr), .branch_target(branch_target));

// ---- verification/amd_decoder_bench.sv ----
// Self-checking bench for the decoder against a table model of the modes.
// Assumes the memory model and the bound checker sit beside the design.
`timescale 1ns/1ps

module amd_decoder_bench;
  import amd_pkg::*;

  typedef struct {
    logic [31:0] code;
    int n;
    amd_mode_t mode;
    logic [15:0] ea;
    int sel;
    logic [7:0] off;
  } amd_case_t;

  localparam logic [15:0] PC0 = 16'h0200;
  logic clock, reset, start, slow, mem_req, mem_ready, busy, done, illegal_reset, use_second_index, has_prebyte;
  logic [15:0] mem_addr, operand, next_pc, eff_addr, branch_target;
  logic [7:0] index_x, index_y, mem_rdata, opcode, prebyte;
  logic [2:0] instr_len;
  amd_mode_t addr_mode;
  amd_case_t cases[$];
  int n_fail = 0;
  int checks = 0;

  amd_decoder dut_u (.clock(clock), .reset(reset), .start(start), .pc_in(PC0), .index_x(index_x),
    .index_y(index_y), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata), .busy(busy), .done(done), .illegal_reset(illegal_reset), .opcode(opcode),
    .prebyte(prebyte), .has_prebyte(has_prebyte), .addr_mode(addr_mode), .op_group(),
    .use_second_index(use_second_index),
    .instr_len(instr_len), .operand(operand), .pointer(), .next_pc(next_pc), .eff_addr(eff_addr),
    .branch_target(branch_target));

  amd_mem_model mem_u (.clock(clock), .slow(slow), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // --------------------------------
  // Compare and closing tasks
  // --------------------------------
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Sel: 0 plain, 1 plus first index, 2 plus second index, 3 address unchecked, 4 illegal
  task automatic add(logic [31:0] code, int n, amd_mode_t mode, logic [15:0] ea, int sel, logic [7:0] off);
    amd_case_t c;
    c = '{code, n, mode, ea, sel, off};
    cases.push_back(c);
  endtask

  task automatic run_case(amd_case_t c);
    int k;
    logic [7:0] idx;
    logic [15:0] tgt;
    logic pre;
    for (k = 0; k < 4; k++) mem_u.mem[PC0 + 16'(k)] = c.code[31 - 8 * k -: 8];
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    k = 0;
    while (done !== 1'b1 && illegal_reset !== 1'b1 && k < 200) begin
      @(negedge clock);
      k++;
    end
    cmp_flag(k < 200, 1'b1);
    cmp_flag(illegal_reset, c.sel == 4);
    if (c.sel != 4) begin
      pre = c.code[31:24] inside {AMD_SECOND_INDEX_PREFIX, AMD_SECOND_INDEX_INDIRECT_PREFIX, AMD_INDIRECT_PREFIX};
      cmp_flag(has_prebyte, pre);
      cmp_word({8'h00, prebyte}, {8'h00, pre ? c.code[31:24] : 8'h00});
      cmp_word({8'h00, opcode}, {8'h00, pre ? c.code[23:16] : c.code[31:24]});
      cmp_word({11'h000, addr_mode}, {11'h000, c.mode});
      cmp_word({13'h0000, instr_len}, 16'(c.n));
      cmp_word(next_pc, PC0 + 16'(c.n));
      idx = c.sel == 1 ? index_x : (c.sel == 2 ? index_y : 8'h00);
      if (c.sel != 3) cmp_word(eff_addr, c.ea + {8'h00, idx});
      tgt = PC0 + 16'(c.n);
      if (c.mode inside {AMD_REL_DIR, AMD_REL_IND, AMD_BIT_DIR_REL, AMD_BIT_IND_REL}) tgt += {{8{c.off[7]}}, c.off};
      cmp_word(branch_target, tgt);
    end
  endtask

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    void'($urandom(32'h020c));
    reset = 1'b1;
    start = 1'b0;
    slow = 1'b0;
    index_x = 8'hff;
    index_y = 8'($urandom);
    mem_u.mem[16'h0010] = 8'hff;
    mem_u.mem[16'h0011] = 8'h34;
    add(32'h9d00_0000, 1, AMD_INHERENT, 16'h0000, 0, 8'h00);
    add(32'ha655_0000, 2, AMD_IMM, 16'h0201, 0, 8'h00);
    add(32'hb610_0000, 2, AMD_SHORT_DIR, 16'h0010, 0, 8'h00);
    add(32'hc612_3400, 3, AMD_LONG_DIR, 16'h1234, 0, 8'h00);
    add(32'hf600_0000, 1, AMD_IDX_NONE, 16'h0000, 1, 8'h00);
    add(32'h90f6_0000, 2, AMD_IDX_NONE, 16'h0000, 2, 8'h00);
    add(32'he6ff_0000, 2, AMD_IDX_SHORT, 16'h00ff, 1, 8'h00);
    add(32'hd612_3400, 3, AMD_IDX_LONG, 16'h1234, 1, 8'h00);
    add(32'h92b6_1000, 3, AMD_IND_SHORT, 16'h00ff, 0, 8'h00);
    add(32'h92c6_1000, 3, AMD_IND_LONG, 16'hff34, 0, 8'h00);
    add(32'h92e6_1000, 3, AMD_INDIDX_SHORT, 16'h00ff, 1, 8'h00);
    add(32'h91e6_1000, 3, AMD_INDIDX_SHORT, 16'h00ff, 2, 8'h00);
    add(32'h92d6_1000, 3, AMD_INDIDX_LONG, 16'hff34, 1, 8'h00);
    add(32'h2780_0000, 2, AMD_REL_DIR, 16'h0000, 0, 8'h80);
    add(32'h9227_1000, 3, AMD_REL_IND, 16'h0000, 0, 8'hff);
    add(32'had7f_0000, 2, AMD_REL_DIR, 16'h0000, 0, 8'h7f);
    add(32'h1010_0000, 2, AMD_BIT_DIR, 16'h0010, 0, 8'h00);
    add(32'h0010_0500, 3, AMD_BIT_DIR_REL, 16'h0010, 0, 8'h05);
    add(32'h9200_1005, 4, AMD_BIT_IND_REL, 16'h00ff, 0, 8'h05);
    add(32'h92a6_5500, 3, AMD_IMM, 16'h0202, 0, 8'h00);
    add(32'h7200_0000, 1, AMD_INHERENT, 16'h0000, 4, 8'h00);
    add(32'ha700_0000, 1, AMD_INHERENT, 16'h0000, 4, 8'h00);
    add(32'h9090_0000, 2, AMD_INHERENT, 16'h0000, 4, 8'h00);
    repeat (16) @(negedge clock);
    reset = 1'b0;
    for (int p = 0; p < 2; p++) begin
      foreach (cases[i]) begin
        run_case(cases[i]);
        $display("test %0d pass %0d ended", i, p);
      end
      slow = 1'b1;
      index_x = 8'($urandom);
      index_y = 8'($urandom);
    end
    tally_and_finish();
  end

  // Two passes of some twenty decodes need far less than this
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    tally_and_finish();
  end
endmodule

// ---- verification/amd_mem_model.sv ----
// Byte-wide program and data memory answering the decoder's fetch handshake.
// Assumes the bench loads mem directly and raises slow to insert stalls.
`timescale 1ns/1ps

module amd_mem_model (
  input wire logic clock,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output logic mem_ready,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic grant;
  logic [7:0] last;

  initial begin
    grant = 1'b1;
    last = 8'h00;
  end

  // Stall pattern moves off the sampling edge
  always @(negedge clock) begin
    grant <= slow ? 1'($urandom % 2) : 1'b1;
  end

  always @(posedge clock) begin
    if (mem_req && mem_ready) begin
      last <= mem_rdata;
    end
  end

  assign mem_ready = mem_req && grant;
  // Unanswered bus shows the inverse of the last byte, never stale data
  assign mem_rdata = mem_ready ? mem[mem_addr] : ~last;
endmodule
